// >>> ptec_pkg.sv
// Package: constants, states and carrier structs for transmit-enable control
`default_nettype none
package ptec_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CHAR_CYC      = 16;     // Cycles per character phase
    localparam int unsigned FRAME_MS      = 16;     // Frame time in ms
    localparam int unsigned FRAME_CYC     = (CLK_HZ / 1000) * FRAME_MS;
    localparam int unsigned SCREEN_CHARS  = 1040;
    localparam int unsigned LINE_CHARS    = 80;
    localparam logic [7:0]  CHAR_STX      = 8'h02;
    localparam logic [7:0]  CHAR_ETX      = 8'h03;
    localparam int unsigned ADDR_MSB      = 7;

    typedef enum logic [2:0] {
        PTEC_IDLE   = 3'b000,
        PTEC_RTS    = 3'b001,
        PTEC_WAITT  = 3'b010,
        PTEC_SEND   = 3'b011,
        PTEC_TOARM  = 3'b100,
        PTEC_TOWAIT = 3'b101,
        PTEC_TOPULS = 3'b110
    } ptec_state_e;

    typedef enum logic [1:0] {
        PTEC_OS_IDLE  = 2'b00,
        PTEC_OS_FRAME = 2'b01,
        PTEC_OS_STEP  = 2'b10,
        PTEC_OS_ADV   = 2'b11
    } ptec_os_e;

    // Phase and frame timing pulses
    typedef struct packed {
        logic ph1;
        logic ph3;
        logic ph4;
        logic frame;
    } ptec_tick_s;

    // Received character with its parity verdict
    typedef struct packed {
        logic       valid;
        logic       parity_err;
        logic [7:0] data;
    } ptec_rx_s;
endpackage : ptec_pkg
`default_nettype wire

// >>> ptec_top.sv
// Polled transmit-enable sequencer with one-step transmit option
`default_nettype none
module ptec_top
    import ptec_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       send_key_i,
    input  wire logic       key_sample_strobe_i,
    input  wire logic       end_key_i,
    input  wire logic       one_step_en_i,
    input  wire logic       line_form_i,
    input  wire logic       rts_cts_fitted_i,
    input  wire logic       clear_to_send_i,
    input  wire ptec_rx_s   rx_char_i,
    input  wire logic [7:0] terminal_address_char_i,
    input  wire logic       end_mark_in_entry_register_i,
    input  wire logic       end_mark_in_first_stage_i,
    input  wire logic       stages_empty_i,
    input  wire logic       step_up_done_i,
    input  wire logic       advance_line_done_i,
    output logic            receive_steer_o,
    output logic            transmit_steer_o,
    output logic            request_to_send_o,
    output logic            init_transmit_o,
    output logic            enter_header_o,
    output logic            first_stage_clear_pulse_o,
    output logic            timeout_pulse_o,
    output logic            one_step_launch_pulse_o,
    output logic            cursor_frame_reset_o,
    output logic            step_up_start_o,
    output logic            advance_line_start_o,
    output logic [7:0]      third_buffer_stage_o,
    output logic [7:0]      second_buffer_stage_o,
    output logic [7:0]      first_buffer_stage_o,
    output logic            end_seen_o,
    output ptec_tick_s      tick_o
);
    localparam int unsigned FW = $clog2(FRAME_CYCLES + 1);
    localparam int unsigned CW = $clog2(4 * CHAR_CYC);

    // Timing generator
    logic [CW-1:0] char_cnt;
    logic [FW-1:0] frame_cnt;
    ptec_tick_s    tick;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            char_cnt <= '0;
        end else begin
            char_cnt <= char_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_cnt <= '0;
        end else if (frame_cnt == FW'(FRAME_CYCLES - 1)) begin
            frame_cnt <= '0;
        end else begin
            frame_cnt <= frame_cnt + 1'b1;
        end
    end

    always_comb begin
        tick.ph1   = (char_cnt == CW'(0));
        tick.ph3   = (char_cnt == CW'(2 * CHAR_CYC));
        tick.ph4   = (char_cnt == CW'(3 * CHAR_CYC));
        tick.frame = (frame_cnt == '0);
    end
    assign tick_o = tick;

    // Frame elapsed latch: set at frame pulse, cleared by restart
    logic frame_seen;
    logic frame_restart;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_seen <= 1'b0;
        end else if (frame_restart) begin
            frame_seen <= 1'b0;
        end else if (tick.frame) begin
            frame_seen <= 1'b1;
        end
    end

    // One-step option
    ptec_os_e os_state;
    logic     launch;
    logic     frame_reset_done;

    // Cursor reset in slot three must come before the launching frame
    // pulse, or the send would start from a stale cursor position
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_reset_done <= 1'b0;
        end else if (os_state != PTEC_OS_FRAME) begin
            frame_reset_done <= 1'b0;
        end else if (tick.ph3) begin
            frame_reset_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            os_state <= PTEC_OS_IDLE;
        end else begin
            case (os_state)
                PTEC_OS_IDLE: begin
                    if (one_step_en_i && end_key_i) begin
                        os_state <= line_form_i ? PTEC_OS_STEP
                                                : PTEC_OS_FRAME;
                    end
                end
                PTEC_OS_FRAME: begin
                    if (tick.frame && frame_reset_done) begin
                        os_state <= PTEC_OS_IDLE;
                    end
                end
                PTEC_OS_STEP: begin
                    if (step_up_done_i) begin
                        os_state <= PTEC_OS_ADV;
                    end
                end
                PTEC_OS_ADV: begin
                    if (advance_line_done_i) begin
                        os_state <= PTEC_OS_IDLE;
                    end
                end
                default: os_state <= PTEC_OS_IDLE;
            endcase
        end
    end

    // Cursor reset in slot three bounds the send to 1040 chars
    assign cursor_frame_reset_o = (os_state == PTEC_OS_FRAME)
                                  && !frame_reset_done
                                  && tick.ph3;
    // Line form bounds the send to one line of 80 chars
    assign step_up_start_o = (os_state == PTEC_OS_IDLE) && one_step_en_i
                             && end_key_i && line_form_i;
    // Advance starts in slot four, in the phase-four cycle itself
    assign advance_line_start_o = (os_state == PTEC_OS_ADV) && tick.ph4;
    assign launch = ((os_state == PTEC_OS_FRAME) && tick.frame
                     && frame_reset_done)
                    || ((os_state == PTEC_OS_ADV)
                        && advance_line_done_i);
    assign one_step_launch_pulse_o = launch;

    // Pending transmit latch
    logic pending;
    logic clear_fire;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pending <= 1'b0;
        end else if ((send_key_i && key_sample_strobe_i) || launch) begin
            pending <= 1'b1;
        end else if (clear_fire) begin
            pending <= 1'b0;
        end
    end

    // Directive decode
    logic start_seen;
    logic addr_match;
    logic prev_stx;
    logic read_ok;
    logic is_etx;

    assign is_etx = rx_char_i.valid && (rx_char_i.data == CHAR_ETX);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_seen <= 1'b0;
            addr_match <= 1'b0;
            prev_stx   <= 1'b0;
        end else if (rx_char_i.valid && receive_steer_o) begin
            prev_stx <= (rx_char_i.data == CHAR_STX);
            if (rx_char_i.data == CHAR_STX) begin
                start_seen <= 1'b1;
                addr_match <= 1'b0;
            end else if (is_etx) begin
                start_seen <= 1'b0;
                addr_match <= 1'b0;
            end else if (prev_stx && start_seen && (rx_char_i.data[6:0]
                         == terminal_address_char_i[6:0])) begin
                addr_match <= 1'b1;
                // Read directive leaves only the match flag
                if (rx_char_i.data[ADDR_MSB]) begin
                    start_seen <= 1'b0;
                end
            end else if (prev_stx) begin
                start_seen <= 1'b0;
            end
        end
    end

    // Write directive simply leaves receive steering on
    assign read_ok = is_etx && !rx_char_i.parity_err && addr_match
                     && !start_seen;

    // Transmit sequencer
    ptec_state_e state;
    logic        cts_ok;
    logic        nobiz_block;

    assign cts_ok = rts_cts_fitted_i ? clear_to_send_i : 1'b1;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= PTEC_IDLE;
        end else begin
            case (state)
                PTEC_IDLE: begin
                    if (read_ok) begin
                        state <= PTEC_RTS;
                    end
                end
                PTEC_RTS: begin
                    if (cts_ok && tick.ph1) begin
                        state <= PTEC_WAITT;
                    end
                end
                PTEC_WAITT: begin
                    if (frame_seen && tick.ph3) begin
                        state <= PTEC_SEND;
                    end
                end
                PTEC_SEND: begin
                    if (end_seen_o && stages_empty_i && tick.ph3) begin
                        state <= PTEC_TOARM;
                    end
                end
                PTEC_TOARM: begin
                    if (tick.ph4) begin
                        state <= PTEC_TOWAIT;
                    end
                end
                PTEC_TOWAIT: begin
                    if (frame_seen) begin
                        state <= PTEC_TOPULS;
                    end
                end
                PTEC_TOPULS: begin
                    // Pulse rides on phase four; its trailing edge ends here
                    if (tick.ph4) begin
                        state <= PTEC_IDLE;
                    end
                end
                default: state <= PTEC_IDLE;
            endcase
        end
    end

    // Restart before each timed wait so an older frame pulse cannot end it
    assign frame_restart = (state == PTEC_RTS && cts_ok && tick.ph1)
                           || (state == PTEC_WAITT && frame_seen
                               && tick.ph3)
                           || (state == PTEC_TOARM && tick.ph4);

    assign init_transmit_o = (state == PTEC_IDLE) && read_ok;
    assign enter_header_o  = (state == PTEC_RTS) && cts_ok && tick.ph1;
    assign timeout_pulse_o = (state == PTEC_TOPULS) && tick.ph4;
    // Receive stays on while idle, even with a transmit pending
    assign receive_steer_o = (state == PTEC_IDLE);
    // RTS and transmit steering hold through the time-out pulse itself
    assign request_to_send_o = (state != PTEC_IDLE);
    assign transmit_steer_o = (state == PTEC_SEND) || (state == PTEC_TOARM)
                              || (state == PTEC_TOWAIT)
                              || (state == PTEC_TOPULS);

    // Message search arm and no-business block
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            nobiz_block <= 1'b0;
        end else if (enter_header_o) begin
            nobiz_block <= 1'b0;
        end else if (state == PTEC_SEND && frame_seen && tick.ph4) begin
            nobiz_block <= 1'b1;
        end
    end

    assign clear_fire = pending && !nobiz_block && (state == PTEC_SEND)
                        && end_mark_in_entry_register_i;
    assign first_stage_clear_pulse_o = clear_fire;

    // End-seen flag; set wins over the idle clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            end_seen_o <= 1'b0;
        end else if (enter_header_o
                     || (transmit_steer_o
                         && end_mark_in_first_stage_i)) begin
            end_seen_o <= 1'b1;
        end else if (timeout_pulse_o || clear_fire) begin
            end_seen_o <= 1'b0;
        end
    end

    // Header buffer stages
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            third_buffer_stage_o  <= 8'h00;
            second_buffer_stage_o <= 8'h00;
            first_buffer_stage_o  <= 8'h00;
        end else if (init_transmit_o) begin
            third_buffer_stage_o  <= 8'h00;
            second_buffer_stage_o <= 8'h00;
        end else if (enter_header_o) begin
            third_buffer_stage_o  <= CHAR_STX;
            second_buffer_stage_o <= terminal_address_char_i;
            first_buffer_stage_o  <= CHAR_ETX;
        end
    end
endmodule : ptec_top
`default_nettype wire

// >>> ptec_sva.sv
// Checker for the polled transmit-enable sequencer
`default_nettype none
module ptec_sva
    import ptec_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       rts_cts_fitted_i,
    input wire logic       clear_to_send_i,
    input wire logic       end_mark_in_entry_register_i,
    input wire logic       receive_steer_o,
    input wire logic       transmit_steer_o,
    input wire logic       request_to_send_o,
    input wire logic       init_transmit_o,
    input wire logic       enter_header_o,
    input wire logic       first_stage_clear_pulse_o,
    input wire logic       timeout_pulse_o,
    input wire logic [7:0] third_buffer_stage_o,
    input wire logic [7:0] second_buffer_stage_o,
    input wire logic [7:0] first_buffer_stage_o,
    input wire logic       end_seen_o,
    input wire ptec_tick_s tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    AST_INIT_RTS: assert property (
        init_transmit_o |=> request_to_send_o && !receive_steer_o
        && second_buffer_stage_o == 8'h00
        && third_buffer_stage_o == 8'h00) else $error("init bad");
    AST_RTS_HOLD: assert property (
        request_to_send_o && !timeout_pulse_o |=> request_to_send_o)
        else $error("rts dropped early");
    AST_TO_RETURN: assert property (
        timeout_pulse_o |=> receive_steer_o && !request_to_send_o
        && !transmit_steer_o) else $error("no idle");
    AST_TO_PH4: assert property (
        timeout_pulse_o |-> tick_o.ph4)
        else $error("timeout off phase four");
    AST_HDR_PH1: assert property (
        enter_header_o |-> tick_o.ph1
        && (clear_to_send_i || !rts_cts_fitted_i)) else $error("hdr bad");
    AST_HDR_LOAD: assert property (
        enter_header_o |=> end_seen_o && third_buffer_stage_o == CHAR_STX
        && first_buffer_stage_o == CHAR_ETX) else $error("hdr load bad");
    AST_STEER_EXCL: assert property (
        !(receive_steer_o && transmit_steer_o))
        else $error("both steerings on");
    AST_PHASES: assert property (
        tick_o.ph1 |-> ##32 tick_o.ph3 ##16 tick_o.ph4 ##16 tick_o.ph1)
        else $error("phase spacing");
    AST_CLR_CAUSE: assert property (
        first_stage_clear_pulse_o
        |-> end_mark_in_entry_register_i && transmit_steer_o)
        else $error("clear without end mark");
    COV_INIT: cover property (init_transmit_o);
    COV_CLR: cover property (first_stage_clear_pulse_o);
    COV_TO: cover property (timeout_pulse_o);
endmodule : ptec_sva
bind ptec_top ptec_sva #(.FRAME_CYCLES(FRAME_CYCLES)) u_ptec_sva (
    .clk_i(clk_i), .reset_i(reset_i), .rts_cts_fitted_i(rts_cts_fitted_i),
    .clear_to_send_i(clear_to_send_i),
    .end_mark_in_entry_register_i(end_mark_in_entry_register_i),
    .receive_steer_o(receive_steer_o), .transmit_steer_o(transmit_steer_o),
    .request_to_send_o(request_to_send_o),
    .init_transmit_o(init_transmit_o), .enter_header_o(enter_header_o),
    .first_stage_clear_pulse_o(first_stage_clear_pulse_o),
    .timeout_pulse_o(timeout_pulse_o),
    .third_buffer_stage_o(third_buffer_stage_o),
    .second_buffer_stage_o(second_buffer_stage_o),
    .first_buffer_stage_o(first_buffer_stage_o),
    .end_seen_o(end_seen_o), .tick_o(tick_o));
`default_nettype wire

// >>> ptec_host_model.sv
// Far-side host: polling directives and clear-to-send reply
`default_nettype none
module ptec_host_model
    import ptec_pkg::*;
#(
    parameter int unsigned CTS_DELAY = 5
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic answer_i,
    input  wire logic request_to_send_i,
    output ptec_rx_s  rx_char_o,
    output logic      clear_to_send_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt;
    // Reply only after a delay, as a modem would; answer_i low withholds it
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i || !request_to_send_i || !answer_i) begin
            cnt             <= 0;
            clear_to_send_o <= 1'b0;
        end else if (cnt == CTS_DELAY) begin
            clear_to_send_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
    initial rx_char_o = '0;
    // Directive sent as three back-to-back characters
    task automatic send_dir(input logic [7:0] addr, input logic bad);
        logic [7:0] seq [3];
        seq = '{CHAR_STX, addr, CHAR_ETX};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            rx_char_o <= {1'b1, bad && (i == 2), seq[i]};
        end
        @(posedge clk_i);
        rx_char_o <= {1'b0, 1'b0, ~CHAR_ETX};
    endtask : send_dir
endmodule : ptec_host_model
`default_nettype wire

// >>> testbench.sv
// Testbench for the polled transmit-enable sequencer
`default_nettype none
module testbench;
    import ptec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FR   = 200;
    localparam logic [7:0]  ADDR = 8'h15;
    logic       clk_i = 0, reset_i = 1, send_key_i = 0, one_step_en_i = 0;
    logic       line_form_i = 0, rts_cts = 1, answer = 1, empty = 0;
    logic [5:0] pls = '0;
    logic       cts, rsteer, tsteer, rts, fsr, stepup, advline;
    logic       init, hdr, fclr, tout, launch, seen;
    logic [7:0] st3, st2, st1;
    ptec_rx_s   rx;
    ptec_tick_s tick;
    logic [8:0] evt;
    int         ev_cnt [9] = '{default: 0};
    int         base [9];
    int         err_count = 0;
    int         checks_done = 0;
    always #12.5 clk_i = ~clk_i;
    assign evt = {advline, stepup, fsr, launch, fclr, tout, tsteer, hdr, init};
    always @(posedge clk_i) for (int k = 0; k < 9; k++) ev_cnt[k] += evt[k];
    ptec_top #(.FRAME_CYCLES(FR)) u_ptec_top (
        .clk_i(clk_i), .reset_i(reset_i), .send_key_i(send_key_i),
        .key_sample_strobe_i(pls[0]), .end_key_i(pls[1]),
        .one_step_en_i(one_step_en_i), .line_form_i(line_form_i),
        .rts_cts_fitted_i(rts_cts), .clear_to_send_i(cts), .rx_char_i(rx),
        .terminal_address_char_i(ADDR),
        .end_mark_in_entry_register_i(pls[2]),
        .end_mark_in_first_stage_i(pls[3]), .stages_empty_i(empty),
        .step_up_done_i(pls[4]), .advance_line_done_i(pls[5]),
        .receive_steer_o(rsteer), .transmit_steer_o(tsteer),
        .request_to_send_o(rts), .init_transmit_o(init),
        .enter_header_o(hdr), .first_stage_clear_pulse_o(fclr),
        .timeout_pulse_o(tout), .one_step_launch_pulse_o(launch),
        .cursor_frame_reset_o(fsr), .step_up_start_o(stepup),
        .advance_line_start_o(advline), .third_buffer_stage_o(st3),
        .second_buffer_stage_o(st2), .first_buffer_stage_o(st1),
        .end_seen_o(seen), .tick_o(tick));
    ptec_host_model u_ptec_host_model (
        .clk_i(clk_i), .reset_i(reset_i), .answer_i(answer),
        .request_to_send_i(rts), .rx_char_o(rx), .clear_to_send_o(cts));
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task automatic pulse(input int k);
        @(posedge clk_i);
        pls[k] <= 1'b1;
        @(posedge clk_i);
        pls[k] <= 1'b0;
    endtask : pulse
    task automatic snap();
        base = ev_cnt;
    endtask : snap
    task automatic cnt_is(input int k, input int e, input string nm);
        chk(nm, 8'(e), 8'(ev_cnt[k] - base[k]));
    endtask : cnt_is
    // Bounded wait for an event since the last snapshot
    task automatic wait_ev(input int k, input string nm);
        int n;
        n = 0;
        while (ev_cnt[k] <= base[k] && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(nm, 8'h01, {7'h00, ev_cnt[k] > base[k]});
        if (ev_cnt[k] <= base[k]) end_sim();
    endtask : wait_ev
    task automatic press();
        @(posedge clk_i);
        send_key_i <= 1'b1;
        pulse(0);
        send_key_i <= 1'b0;
    endtask : press
    // Read directive through to time-out; mark chooses message or none
    task automatic read_run(input logic mark);
        press();
        snap();
        u_ptec_host_model.send_dir(ADDR | 8'h80, 1'b0);
        wait_ev(0, "init");
        chk("rts", 8'h01, {7'h00, rts});
        chk("recv", 8'h00, {7'h00, rsteer});
        wait_ev(1, "header");
        @(posedge clk_i);
        #1;
        chk("st3", CHAR_STX, st3);
        chk("st2", ADDR, st2);
        chk("st1", CHAR_ETX, st1);
        chk("seen", 8'h01, {7'h00, seen});
        wait_ev(2, "tsteer");
        if (mark) begin
            // Second pass comes early, so only the spent latch can stop it
            pulse(2);
            pulse(2);
            pulse(3);
        end else begin
            // Late end mark, after the search frame, must stay blocked
            repeat (FR + 70) @(posedge clk_i);
            pulse(2);
        end
        cnt_is(4, 32'(mark), "fclear");
        @(posedge clk_i);
        empty <= 1'b1;
        wait_ev(3, "timeout");
        @(posedge clk_i);
        empty <= 1'b0;
        #1;
        chk("recv", 8'h01, {7'h00, rsteer});
        chk("rts", 8'h00, {7'h00, rts});
    endtask : read_run
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        chk("recv", 8'h01, {7'h00, rsteer});
        chk("st1", 8'h00, st1);
        // Write directive, then read with bad parity: neither transmits
        press();
        snap();
        u_ptec_host_model.send_dir(ADDR, 1'b0);
        u_ptec_host_model.send_dir(ADDR | 8'h80, 1'b1);
        repeat (10) @(posedge clk_i);
        cnt_is(0, 0, "init");
        chk("recv", 8'h01, {7'h00, rsteer});
        read_run(1'b0);
        // Option not fitted and the far side silent: CTS is taken as true
        @(posedge clk_i);
        rts_cts <= 1'b0;
        answer  <= 1'b0;
        read_run(1'b1);
        @(posedge clk_i);
        one_step_en_i <= 1'b1;
        snap();
        pulse(1);
        wait_ev(6, "framereset");
        wait_ev(5, "launch");
        cnt_is(6, 1, "framereset");
        @(posedge clk_i);
        line_form_i <= 1'b1;
        snap();
        pulse(1);
        wait_ev(7, "stepup");
        pulse(4);
        wait_ev(8, "advance");
        pulse(5);
        wait_ev(5, "launch");
        repeat (10) @(posedge clk_i);
        snap();
        repeat (FR) @(posedge clk_i);
        cnt_is(8, 0, "advance");
        cnt_is(7, 0, "stepup");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
